// file: rtl/spdif_rx_lock_defs.svh
// Offsets, field positions, reset values and counts of the receiver lock control block.
// Assumes inclusion by bare name from rtl/.
// Behaviour
// - Bit 0 of the lock status register is a read-only flag, 1 while locked and 0 otherwise.
// - With quick-acquire at 0, lock is declared after 64 valid samples in a row.
// - With quick-acquire (bit 3) at 1, lock is declared after 8 valid samples in a row.
// - With hold policy (bit 2) at 0, the frame clock keeps running after loss of lock.
// - With hold policy at 1, the frame clock output stops at once on loss of lock.
// - Word length field bits 1:0 selects 24, 20 or 16 bits for codes 00, 01, 10.
// - Word length code 11 takes the length from the stream's channel status.
// - The control register resets to all zeros.
// - Audio output is muted automatically when lock is lost.
// - Without auto-resume, audio stays muted after relock until software toggles it 0-1-0.
`ifndef SPDIF_RX_LOCK_DEFS_SVH
`define SPDIF_RX_LOCK_DEFS_SVH

// ****************************************
// Register indices; byte address = 4 * index
// ****************************************
`define IDX_LOCK_STATUS 16'hf600
`define IDX_RX_CONTROL 16'hf601
`define IDX_AUTO_RESUME 16'hf604
`define IDX_IRQ_STATUS 16'hf610
`define IDX_IRQ_CLEAR 16'hf611
`define IDX_IRQ_ENABLE 16'hf612

// ****************************************
// Fields
// ****************************************
`define BIT_LOCK 0
`define BIT_QUICK 3
`define BIT_HOLD 2
`define BIT_WLEN_LO 0
`define BIT_RESUME 0
`define BIT_IRQ_LOCK 0
`define BIT_IRQ_LOSS 1

// ****************************************
// Reset values and counts
// ****************************************
`define RST_RX_CONTROL 16'h0000
`define RST_AUTO_RESUME 16'h0000
`define COUNT_NORMAL 7'd64
`define COUNT_QUICK 7'd8
`define WLEN_24 5'd24
`define WLEN_20 5'd20
`define WLEN_16 5'd16

`endif

// file: rtl/spdif_rx_lock_pkg.sv
// Types shared by the receiver lock control block.
// Assumes nothing beyond a SystemVerilog compiler.
package spdif_rx_lock_pkg;
   typedef enum logic [2:0] {
      ST_HUNT = 3'b001,
      ST_LOCKED = 3'b010,
      ST_MUTED = 3'b100
   } lock_state_e;
endpackage

// file: rtl/lock_ctl_if.sv
// Control and status passed between the register slave and the lock engine.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface lock_ctl_if;
   logic quickAcquire;
   logic holdPolicy;
   logic autoResume;
   logic resumeToggled;
   logic locked;
   logic muted;
   logic lockGained;
   logic lockLost;
   modport regs (output quickAcquire, output holdPolicy, output autoResume,
      output resumeToggled, input locked, input muted, input lockGained, input lockLost);
   modport engine (input quickAcquire, input holdPolicy, input autoResume,
      input resumeToggled, output locked, output muted, output lockGained, output lockLost);
endinterface
`default_nettype wire

// file: rtl/lock_engine.sv
// Lock acquisition, loss handling and mute sequencing.
// Assumes sampleValid/sampleBad pulses come from the biphase decoder in clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "spdif_rx_lock_defs.svh"
module lock_engine
   import spdif_rx_lock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sampleValid,
   input wire logic sampleBad,
   lock_ctl_if.engine ctl
);
   lock_state_e state_reg;
   lock_state_e state_next;
   logic [6:0] run_reg;
   logic [6:0] run_next;
   logic [6:0] target;
   logic reached;
   logic heldMute_reg;

   assign target = ctl.quickAcquire ? `COUNT_QUICK : `COUNT_NORMAL;
   assign reached = sampleValid && (run_reg + 7'd1 >= target);
   assign run_next = sampleBad ? 7'd0 : (sampleValid && !reached) ? run_reg + 7'd1 :
      reached ? 7'd0 : run_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HUNT:
         begin
            if (reached)
               state_next = ST_LOCKED;
         end
         ST_LOCKED:
         begin
            if (sampleBad)
               state_next = ST_HUNT;
         end
         default:
            state_next = ST_HUNT;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_HUNT;
         run_reg <= 7'd0;
      end
      else
      begin
         state_reg <= state_next;
         run_reg <= (state_reg == ST_LOCKED) ? 7'd0 : run_next;
      end
   end

   // Mute holds from first loss until resume rules release it
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         heldMute_reg <= 1'b0;
      else if (ctl.lockLost)
         heldMute_reg <= 1'b1;
      else if (ctl.resumeToggled || (ctl.autoResume && state_reg == ST_LOCKED))
         heldMute_reg <= 1'b0;
   end

   assign ctl.locked = (state_reg == ST_LOCKED);
   assign ctl.lockGained = (state_reg == ST_HUNT) && reached;
   assign ctl.lockLost = (state_reg == ST_LOCKED) && sampleBad;
   assign ctl.muted = heldMute_reg || (state_reg != ST_LOCKED);
endmodule // lock_engine
`default_nettype wire

// file: rtl/spdif_rx_lock_control.sv
// Receiver lock control: AXI4-Lite registers, word length select, frame clock gating, interrupt.
// Assumes biphase decoder outputs and frame clock tick synchronous to clk_sys.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "spdif_rx_lock_defs.svh"
module spdif_rx_lock_control
   import spdif_rx_lock_pkg::*;
#(
   parameter int ADDR_W = 18
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic sampleValid,
   input wire logic sampleBad,
   input wire logic frameTick,
   input wire logic [4:0] channelStatusLength,
   output logic frameClockOut,
   output logic audioMute,
   output logic [4:0] wordLength,
   output logic irq
);
   // Register index sits in address bits 17:2
   if (ADDR_W < 18)
   begin : g_addrCheck
      $error("ADDR_W too small for register map");
   end

   lock_ctl_if ctl ();

   logic [15:0] control_reg;
   logic resume_reg;
   logic resumeDelayed_reg;
   logic [1:0] irqStatus_reg;
   logic [1:0] irqEnable_reg;
   logic awHeld_reg;
   logic wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic lossSeen_reg;

   // ****************************************
   // Lock engine
   // ****************************************
   lock_engine engine (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sampleValid(sampleValid),
      .sampleBad(sampleBad),
      .ctl(ctl)
   );

   assign ctl.quickAcquire = control_reg[`BIT_QUICK];
   assign ctl.holdPolicy = control_reg[`BIT_HOLD];
   assign ctl.autoResume = resume_reg;
   assign ctl.resumeToggled = resumeDelayed_reg && !resume_reg;

   // ****************************************
   // Write channel
   // ****************************************
   function automatic logic [15:0] regIndex(input logic [ADDR_W-1:0] a);
      regIndex = a[17:2];
   endfunction

   wire logic doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   wire logic [15:0] wIdx = regIndex(awAddr_reg);
   wire logic lowLanes = wStrb_reg[0];
   wire logic hitCtl = (wIdx == `IDX_RX_CONTROL);
   wire logic hitResume = (wIdx == `IDX_AUTO_RESUME);
   wire logic hitClear = (wIdx == `IDX_IRQ_CLEAR);
   wire logic hitEnable = (wIdx == `IDX_IRQ_ENABLE);
   wire logic hitRo = (wIdx == `IDX_LOCK_STATUS) || (wIdx == `IDX_IRQ_STATUS);
   wire logic wMapped = hitCtl || hitResume || hitClear || hitEnable || hitRo;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wMapped ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         control_reg <= `RST_RX_CONTROL;
         resume_reg <= 1'b0;
         resumeDelayed_reg <= 1'b0;
         irqEnable_reg <= 2'b00;
      end
      else
      begin
         resumeDelayed_reg <= resume_reg;
         if (doWrite && lowLanes && hitCtl)
            control_reg <= {12'h000, wData_reg[3:0]};
         if (doWrite && lowLanes && hitResume)
            resume_reg <= wData_reg[`BIT_RESUME];
         if (doWrite && lowLanes && hitEnable)
            irqEnable_reg <= wData_reg[1:0];
      end
   end

   // ****************************************
   // Interrupt status: set wins over clear
   // ****************************************
   wire logic [1:0] irqEvents = {ctl.lockLost, ctl.lockGained};
   wire logic [1:0] irqClr = (doWrite && lowLanes && hitClear) ? wData_reg[1:0] : 2'b00;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         irqStatus_reg <= 2'b00;
         irq <= 1'b0;
      end
      else
      begin
         irqStatus_reg <= (irqStatus_reg & ~irqClr) | irqEvents;
         irq <= |(((irqStatus_reg & ~irqClr) | irqEvents) & irqEnable_reg);
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   wire logic [15:0] rIdx = regIndex(s_axi_araddr);
   wire logic rMapped = (rIdx == `IDX_LOCK_STATUS) || (rIdx == `IDX_RX_CONTROL) ||
      (rIdx == `IDX_AUTO_RESUME) || (rIdx == `IDX_IRQ_STATUS) ||
      (rIdx == `IDX_IRQ_ENABLE) || (rIdx == `IDX_IRQ_CLEAR);
   wire logic [31:0] rValue =
      (rIdx == `IDX_LOCK_STATUS) ? {31'h0, ctl.locked} :
      (rIdx == `IDX_RX_CONTROL) ? {16'h0000, control_reg} :
      (rIdx == `IDX_AUTO_RESUME) ? {31'h0, resume_reg} :
      (rIdx == `IDX_IRQ_STATUS) ? {30'h0, irqStatus_reg} :
      (rIdx == `IDX_IRQ_ENABLE) ? {30'h0, irqEnable_reg} : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rValue;
         s_axi_rresp <= rMapped ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign s_axi_arready = !s_axi_rvalid;

   // ****************************************
   // Word length and audio outputs
   // ****************************************
   wire logic [1:0] wlenCode = control_reg[`BIT_WLEN_LO +: 2];
   wire logic [4:0] wlenSel = (wlenCode == 2'b00) ? `WLEN_24 :
      (wlenCode == 2'b01) ? `WLEN_20 :
      (wlenCode == 2'b10) ? `WLEN_16 : channelStatusLength;
   // Hold policy 1 gates the frame clock from the first loss until relock
   wire logic gateFrame = ctl.holdPolicy && (ctl.lockLost || lossSeen_reg);

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wordLength <= `WLEN_24;
         frameClockOut <= 1'b0;
         audioMute <= 1'b1;
         lossSeen_reg <= 1'b0;
      end
      else
      begin
         wordLength <= wlenSel;
         lossSeen_reg <= ctl.lockLost ? 1'b1 : (ctl.lockGained ? 1'b0 : lossSeen_reg);
         frameClockOut <= frameTick && !gateFrame;
         audioMute <= ctl.muted || ctl.lockLost;
      end
   end
endmodule // spdif_rx_lock_control
`default_nettype wire

// file: sim/spdif_rx_lock_control_props.sv
// Port-level checks of the receiver lock control block.
// Assumes a bind onto spdif_rx_lock_control; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module spdif_rx_lock_control_props
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic sampleValid,
   input wire logic sampleBad,
   input wire logic frameTick,
   input wire logic [4:0] channelStatusLength,
   input wire logic frameClockOut,
   input wire logic audioMute,
   input wire logic [4:0] wordLength,
   input wire logic irq
);
   // *****
   // Run of valid samples since the last bad one
   // *****
   logic [6:0] runCount;
   always_ff @(posedge clk_sys or negedge nrst)
      if (!nrst)
         runCount <= 7'h00;
      else if (sampleBad)
         runCount <= 7'h00;
      else if (sampleValid && runCount != 7'h7f)
         runCount <= runCount + 7'h01;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_muted; ##[1:3] audioMute; endsequence
   property p_mute_loss; sampleBad |-> s_muted; endproperty
   property p_unmute; $fell(audioMute) |-> runCount >= 7'd8; endproperty
   property p_fclk; frameClockOut |-> $past(frameTick); endproperty
   property p_wlen; wordLength == 5'd24 || wordLength == 5'd20 || wordLength == 5'd16
      || wordLength == $past(channelStatusLength); endproperty
   property p_rst; $rose(nrst) |-> wordLength == 5'd24 && audioMute && !irq; endproperty
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_mute_loss: assert property (p_mute_loss)
      else $error("no mute after bad sample");
   a_unmute: assert property (p_unmute)
      else $error("unmute with short valid run");
   a_fclk: assert property (p_fclk)
      else $error("frame clock not from tick");
   a_wlen: assert property (p_wlen)
      else $error("bad word length");
   a_rst: assert property (p_rst)
      else $error("bad reset outputs");
   a_bdone: assert property (p_bdone)
      else $error("write response repeated");
   a_rdone: assert property (p_rdone)
      else $error("read response repeated");
   a_rhi: assert property (p_rhi)
      else $error("upper read bits set");
endmodule // spdif_rx_lock_control_props
`default_nettype wire

// file: sim/spdif_tx_model.sv
// Transmitter as seen through the biphase decoder: sample pulses and frame tick.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
`default_nettype none
module spdif_tx_model
(
   input wire logic clk_sys,
   output logic sampleValid,
   output logic sampleBad,
   output logic frameTick
);
   initial
   begin
      sampleValid = 1'b0;
      sampleBad = 1'b0;
      frameTick = 1'b0;
   end
   // Frame tick moves only with samples
   task automatic burst(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         sampleValid <= 1'b1;
         frameTick <= ~frameTick;
         @(posedge clk_sys);
         sampleValid <= 1'b0;
      end
   endtask
   task automatic glitch();
      @(posedge clk_sys);
      sampleBad <= 1'b1;
      @(posedge clk_sys);
      sampleBad <= 1'b0;
   endtask
endmodule // spdif_tx_model
`default_nettype wire

// file: sim/spdif_rx_lock_control_tb.sv
// Self-checking bench of the receiver lock control block.
// Assumes rtl/ on the include path and the transmitter model.
`timescale 1ns/1ns
`default_nettype none
`include "spdif_rx_lock_defs.svh"
module spdif_rx_lock_control_tb;
   logic clk_sys = 1'b0, nrst = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [4:0] channelStatusLength = 5'h12, wordLength;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [1:0] lastBresp;
   logic sampleValid, sampleBad, frameTick, frameClockOut, audioMute, irq;
   int failCount = 0, nChecks = 0, cycles = 0, fcRises = 0;
   always #2 clk_sys = ~clk_sys;
   spdif_rx_lock_control i_spdif_rx_lock_control (.clk_sys, .nrst, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .sampleValid, .sampleBad, .frameTick, .channelStatusLength,
      .frameClockOut, .audioMute, .wordLength, .irq);
   spdif_tx_model i_spdif_tx_model (.clk_sys, .sampleValid, .sampleBad, .frameTick);
   always @(posedge frameClockOut) fcRises++;
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failCount++;
         wrapUp();
      end
   end
   // *****
   // Bus and compare tasks
   // *****
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      logic aw = 1'b0, w = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= ~aw;
         s_axi_wvalid <= ~w;
      end
      while (!s_axi_bvalid);
      lastBresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         a = a | s_axi_arready;
         s_axi_arvalid <= ~a;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (g !== e)
      begin
         failCount++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic rdChk(input string nm, input logic [15:0] idx, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(nm, e, d);
   endtask
   // *****
   // Scenarios
   // *****
   task automatic t_reset();
      wr(`IDX_LOCK_STATUS, 16'h0001);
      chk("ro bresp", 32'h0, {30'h0, lastBresp});
      rdChk("lock reset", `IDX_LOCK_STATUS, 32'h0);
      rdChk("ctrl reset", `IDX_RX_CONTROL, 32'h0);
      chk("wlen reset", 32'd24, {27'h0, wordLength});
      chk1("mute reset", 1'b1, audioMute);
   endtask
   task automatic t_wlen();
      logic [4:0] wlenExp [4] = '{5'd24, 5'd20, 5'd16, 5'd18};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++)
      begin
         wr(`IDX_RX_CONTROL, 16'(i));
         repeat (2) @(posedge clk_sys);
         chk("wlen", {27'h0, wlenExp[i]}, {27'h0, wordLength});
      end
      channelStatusLength <= 5'h10;
      repeat (2) @(posedge clk_sys);
      chk("wlen auto", 32'd16, {27'h0, wordLength});
      s_axi_wstrb <= 4'he;
      wr(`IDX_RX_CONTROL, 16'h0001);
      s_axi_wstrb <= 4'hf;
      rdChk("strb off", `IDX_RX_CONTROL, 32'h3);
      wr(`IDX_RX_CONTROL, 16'hfffc);
      rdChk("ctrl bits", `IDX_RX_CONTROL, 32'hc);
      wr(`IDX_RX_CONTROL, 16'h0000);
      rd(16'h0123, d, r);
      chk("unmapped resp", 32'h2, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      wr(16'h0123, 16'h0000);
      chk("unmapped bresp", 32'h2, {30'h0, lastBresp});
   endtask
   task automatic t_normal();
      wr(`IDX_IRQ_ENABLE, 16'h0003);
      i_spdif_tx_model.burst(63);
      rdChk("lock63", `IDX_LOCK_STATUS, 32'h0);
      i_spdif_tx_model.burst(1);
      rdChk("lock64", `IDX_LOCK_STATUS, 32'h1);
      chk1("irq set", 1'b1, irq);
      rdChk("irq status set", `IDX_IRQ_STATUS, 32'h1);
      wr(`IDX_IRQ_ENABLE, 16'h0000);
      repeat (2) @(posedge clk_sys);
      chk1("irq masked", 1'b0, irq);
      wr(`IDX_IRQ_CLEAR, 16'h0003);
      wr(`IDX_IRQ_ENABLE, 16'h0003);
      repeat (2) @(posedge clk_sys);
      chk1("irq cleared", 1'b0, irq);
      rdChk("irq status", `IDX_IRQ_STATUS, 32'h0);
   endtask
   task automatic t_hold();
      wr(`IDX_RX_CONTROL, 16'h000c);
      i_spdif_tx_model.glitch();
      rdChk("lock lost", `IDX_LOCK_STATUS, 32'h0);
      chk1("mute lost", 1'b1, audioMute);
      fcRises = 0;
      i_spdif_tx_model.burst(7);
      rdChk("lock7", `IDX_LOCK_STATUS, 32'h0);
      chk("fclk held", 32'h0, fcRises);
      i_spdif_tx_model.burst(1);
      rdChk("lock8", `IDX_LOCK_STATUS, 32'h1);
      chk1("mute kept", 1'b1, audioMute);
      wr(`IDX_AUTO_RESUME, 16'h0001);
      wr(`IDX_AUTO_RESUME, 16'h0000);
      repeat (3) @(posedge clk_sys);
      chk1("mute freed", 1'b0, audioMute);
   endtask
   task automatic t_run();
      wr(`IDX_RX_CONTROL, 16'h0008);
      i_spdif_tx_model.glitch();
      fcRises = 0;
      i_spdif_tx_model.burst(4);
      chk1("mute run", 1'b1, audioMute);
      chk1("fclk runs", 1'b1, fcRises != 0);
      wr(`IDX_AUTO_RESUME, 16'h0001);
      i_spdif_tx_model.burst(4);
      repeat (3) @(posedge clk_sys);
      chk1("auto resume", 1'b0, audioMute);
   endtask
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_wlen();
      t_normal();
      t_hold();
      t_run();
      wrapUp();
   end
endmodule // spdif_rx_lock_control_tb
bind spdif_rx_lock_control spdif_rx_lock_control_props i_spdif_rx_lock_control_props (
   .clk_sys, .nrst, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .sampleValid, .sampleBad, .frameTick, .channelStatusLength,
   .frameClockOut, .audioMute, .wordLength, .irq);
`default_nettype wire
